// ---- src/relay_sel_pkg.sv ----
// constants, register map and code decoding for the relay output selector
package relay_sel_pkg;

	// ********************************
	// widths
	// ********************************
	localparam int SEL_W     = 16;
	localparam int SIG_COUNT = 100;
	localparam int AW        = 5;
	localparam int DW        = 32;
	localparam int RELAYS    = 3;
	localparam int IRQ_W     = 3;

	// ********************************
	// register byte offsets
	// ********************************
	localparam logic [AW-1:0] OFF_SEL1     = 5'h00;
	localparam logic [AW-1:0] OFF_SEL2     = 5'h04;
	localparam logic [AW-1:0] OFF_SEL3     = 5'h08;
	localparam logic [AW-1:0] OFF_STATE    = 5'h0C;
	localparam logic [AW-1:0] OFF_IRQ_STAT = 5'h10;
	localparam logic [AW-1:0] OFF_IRQ_MASK = 5'h14;

	// ********************************
	// reset values and fields
	// ********************************
	localparam logic [SEL_W-1:0] RST_SEL1         = 16'h0000;
	localparam logic [SEL_W-1:0] RST_SEL2         = 16'h0001;
	localparam logic [SEL_W-1:0] RST_SEL3         = 16'h0002;
	localparam logic [SEL_W-1:0] RST_SEL3_COMPACT = 16'h0004;
	localparam logic [SEL_W-1:0] CODE_NONE        = 16'h270F;
	localparam int IRQ_REJECT = 0;
	localparam int IRQ_ALARM  = 1;
	localparam int IRQ_CHANGE = 2;
	localparam int ST_ALARM   = 3;
	localparam int ST_COMPACT = 4;
	localparam int ST_ANALOG  = 5;

	// positive-logic codes only; the compact host knows a smaller set
	function automatic logic valid_code(input logic [SEL_W-1:0] c, input logic compact);
		if (compact) begin
			return c inside {16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0007, 16'h0008,
				[16'h000B:16'h0010], 16'h0014, 16'h0019, 16'h001A, 16'h002E, 16'h002F,
				16'h0040, 16'h005A, 16'h005B, 16'h005F, 16'h0060, 16'h0062, 16'h0063,
				CODE_NONE};
		end
		return c inside {
			[16'h0000:16'h0008], [16'h000A:16'h0014], [16'h0019:16'h001C],
			[16'h001E:16'h0024], 16'h0027,
			[16'h0029:16'h002F], 16'h0040,
			[16'h0046:16'h004E],
			[16'h0054:16'h005B], [16'h005E:16'h0063], CODE_NONE};
	endfunction

endpackage

// ---- src/relay_avalon_slave.sv ----
// avalon-mm slave front end with one wait state per access
`timescale 1ns/100ps
`default_nettype none
module relay_avalon_slave (
	// clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     rst_i,
	// bus
	input  wire logic                     read_i,
	input  wire logic                     write_i,
	output logic [relay_sel_pkg::DW-1:0]  readdata_o,
	output logic                          waitrequest_o,
	// core side
	input  wire logic [relay_sel_pkg::DW-1:0] rd_data_i,
	output logic                          wr_en_o
);
	import relay_sel_pkg::*;

	logic ack;

	// the wait state lets read data come from a register
	assign waitrequest_o = (read_i | write_i) & ~ack;
	assign wr_en_o       = write_i & ack;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= (read_i | write_i) & ~ack;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			readdata_o <= '0;
		end else if (read_i & ~ack) begin
			readdata_o <= rd_data_i;
		end
	end
endmodule
`default_nettype wire

// ---- src/relay_driver.sv ----
// one relay: picks the selected status bit and drives both contacts
`timescale 1ns/100ps
`default_nettype none
module relay_driver #(
	parameter int SIG_COUNT = relay_sel_pkg::SIG_COUNT
) (
	// clock and reset
	input  wire logic                            clock_i,
	input  wire logic                            rst_i,
	// host side
	input  wire logic [SIG_COUNT-1:0]            status_vec_i,
	input  wire logic [relay_sel_pkg::SEL_W-1:0] select_i,
	input  wire logic                            alarm_i,
	// contacts
	output logic                                 no_closed_o,
	output logic                                 nc_closed_o
);
	import relay_sel_pkg::*;

	localparam int IW = $clog2(SIG_COUNT);
	logic on;

	// codes beyond the vector, such as no function, leave the relay off
	always_comb begin
		on = 1'b0;
		if (select_i < SEL_W'(SIG_COUNT)) begin
			on = status_vec_i[select_i[IW-1:0]];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			no_closed_o <= 1'b0;
			nc_closed_o <= 1'b1;
		end else begin
			no_closed_o <= on & ~alarm_i;
			nc_closed_o <= ~(on & ~alarm_i);
		end
	end
endmodule
`default_nettype wire

// ---- src/relay_output_selector.sv ----
// relay output selector: three software-selected status relays
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module relay_output_selector #(
	parameter int SIG_COUNT = relay_sel_pkg::SIG_COUNT
) (
	// clock and reset
	input  wire logic                          clock_i,
	input  wire logic                          rst_i,
	// avalon-mm slave
	input  wire logic [relay_sel_pkg::AW-1:0]  address_i,
	input  wire logic                          read_i,
	input  wire logic                          write_i,
	input  wire logic [relay_sel_pkg::DW-1:0]  writedata_i,
	output logic [relay_sel_pkg::DW-1:0]       readdata_o,
	output logic                               waitrequest_o,
	// host status and configuration
	input  wire logic [SIG_COUNT-1:0]          status_vec_i,
	input  wire logic                          option_alarm_i,
	input  wire logic                          compact_variant_i,
	input  wire logic                          analog_option_i,
	// relay contacts
	output logic [relay_sel_pkg::RELAYS-1:0]   no_closed_o,
	output logic [relay_sel_pkg::RELAYS-1:0]   nc_closed_o,
	// interrupt
	output logic                               irq_o
);
	import relay_sel_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [SEL_W-1:0]  sel [RELAYS];
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  next_irq_event;
	logic [DW-1:0]     rd_data;
	logic              wr_en;
	logic              alarm_q;
	logic [RELAYS-1:0] no_q;
	logic              sel_hit;
	logic [1:0]        sel_idx;
	logic              wr_ok;
	logic [SEL_W-1:0]  wr_code;

	// ****************************************
	// bus front end
	// ****************************************
	relay_avalon_slave u_bus (
		.clock_i       (clock_i),
		.rst_i         (rst_i),
		.read_i        (read_i),
		.write_i       (write_i),
		.readdata_o    (readdata_o),
		.waitrequest_o (waitrequest_o),
		.rd_data_i     (rd_data),
		.wr_en_o       (wr_en)
	);

	// ****************************************
	// selection write decode
	// ****************************************
	// consecutive selection slots
	assign sel_hit = (address_i == OFF_SEL1) || (address_i == OFF_SEL2)
		|| (address_i == OFF_SEL3);
	assign sel_idx = address_i[3:2];
	assign wr_code = writedata_i[SEL_W-1:0];

	// upper bits or unknown codes refuse the write
	always_comb begin
		wr_ok = valid_code(wr_code, compact_variant_i)
			&& (writedata_i[DW-1:SEL_W] == '0);
		// locked while the analog option is fitted
		if (address_i == OFF_SEL3 && analog_option_i) begin
			wr_ok = 1'b0;
		end
	end

	// only the third slot's reset default depends on the host variant
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sel[0] <= RST_SEL1;
			sel[1] <= RST_SEL2;
			sel[2] <= compact_variant_i ? RST_SEL3_COMPACT : RST_SEL3;
		end else if (wr_en && sel_hit && wr_ok) begin
			sel[sel_idx] <= wr_code;
		end
	end

	// ****************************************
	// relays
	// ****************************************
	// one registered driver per relay
	for (genvar r = 0; r < RELAYS; r++) begin : g_relay
		relay_driver #(
			.SIG_COUNT (SIG_COUNT)
		) u_drv (
			.clock_i      (clock_i),
			.rst_i        (rst_i),
			.status_vec_i (status_vec_i),
			.select_i     (sel[r]),
			.alarm_i      (option_alarm_i),
			.no_closed_o  (no_closed_o[r]),
			.nc_closed_o  (nc_closed_o[r])
		);
	end

	// ****************************************
	// interrupts
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			alarm_q <= 1'b0;
			no_q    <= '0;
		end else begin
			alarm_q <= option_alarm_i;
			no_q    <= no_closed_o;
		end
	end

	always_comb begin
		next_irq_event             = '0;
		next_irq_event[IRQ_REJECT] = wr_en && sel_hit && !wr_ok;
		next_irq_event[IRQ_ALARM]  = option_alarm_i && !alarm_q;
		next_irq_event[IRQ_CHANGE] = no_closed_o != no_q;
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_status <= '0;
		end else if (wr_en && address_i == OFF_IRQ_STAT) begin
			irq_status <= (irq_status & ~writedata_i[IRQ_W-1:0]) | next_irq_event;
		end else begin
			irq_status <= irq_status | next_irq_event;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_mask <= '0;
		end else if (wr_en && address_i == OFF_IRQ_MASK) begin
			irq_mask <= writedata_i[IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rd_data = '0;
		unique case (address_i)
			OFF_SEL1:     rd_data[SEL_W-1:0] = sel[0];
			OFF_SEL2:     rd_data[SEL_W-1:0] = sel[1];
			// hidden while the analog option is fitted
			OFF_SEL3:     rd_data[SEL_W-1:0] = analog_option_i ? '0 : sel[2];
			OFF_STATE: begin
				rd_data[RELAYS-1:0] = no_closed_o;
				rd_data[ST_ALARM]   = option_alarm_i;
				rd_data[ST_COMPACT] = compact_variant_i;
				rd_data[ST_ANALOG]  = analog_option_i;
			end
			OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_status;
			OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask;
			default:      rd_data = '0;
		endcase
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// reference pick of a status bit by code, for checking only
	function automatic logic pick(input logic [SEL_W-1:0] c, input logic [SIG_COUNT-1:0] v);
		if (c < SEL_W'(SIG_COUNT)) begin
			return v[c[$clog2(SIG_COUNT)-1:0]];
		end
		return 1'b0;
	endfunction

	sequence s_request;
		(read_i || write_i) && waitrequest_o;
	endsequence

	sequence s_answer;
		!waitrequest_o && (read_i || write_i);
	endsequence

	property p_one_wait;
		s_request |=> s_answer;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("answer not one cycle after request");

	property p_alarm_off;
		option_alarm_i |=> (no_closed_o == '0) && (nc_closed_o == '1);
	endproperty
	a_alarm_off: assert property (p_alarm_off)
		else $error("relay closed during option alarm");

	property p_follow;
		!option_alarm_i |=> no_closed_o[0] == pick($past(sel[0]), $past(status_vec_i))
			&& no_closed_o[1] == pick($past(sel[1]), $past(status_vec_i))
			&& no_closed_o[2] == pick($past(sel[2]), $past(status_vec_i));
	endproperty
	a_follow: assert property (p_follow)
		else $error("relay does not follow its selected signal");

	property p_contacts;
		nc_closed_o == ~no_closed_o;
	endproperty
	a_contacts: assert property (p_contacts)
		else $error("open and closed contacts disagree");

	property p_defaults;
		$fell(rst_i) |-> sel[0] == RST_SEL1 && sel[1] == RST_SEL2
			&& sel[2] == ($past(compact_variant_i) ? RST_SEL3_COMPACT : RST_SEL3);
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("selection reset value wrong");

	property p_reject;
		wr_en && sel_hit && !valid_code(wr_code, compact_variant_i)
			|=> $stable(sel[0]) && $stable(sel[1]) && $stable(sel[2]) && irq_status[IRQ_REJECT];
	endproperty
	a_reject: assert property (p_reject)
		else $error("unsupported code was taken");

	property p_accept;
		wr_en && address_i == OFF_SEL2 && wr_ok |=> sel[1] == $past(wr_code);
	endproperty
	a_accept: assert property (p_accept)
		else $error("valid selection write lost");

	property p_analog_lock;
		wr_en && address_i == OFF_SEL3 && analog_option_i |=> $stable(sel[2]);
	endproperty
	a_analog_lock: assert property (p_analog_lock)
		else $error("locked selection changed");

	property p_negative;
		wr_en && sel_hit && writedata_i[DW-1:SEL_W] != '0
			|=> $stable(sel[0]) && $stable(sel[1]) && $stable(sel[2]);
	endproperty
	a_negative: assert property (p_negative)
		else $error("out-of-range code accepted");

	property p_reset_off;
		@(posedge clock_i) disable iff (1'b0)
			rst_i |=> no_closed_o == '0 && nc_closed_o == '1;
	endproperty
	a_reset_off: assert property (p_reset_off)
		else $error("relay closed after reset");

	// a set status bit whose mask bit is set keeps the line up until software clears it
	property p_irq;
		(irq_status & irq_mask) != '0 && !wr_en |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt line wrong");

	property p_alarm_irq;
		option_alarm_i && !alarm_q |=> irq_status[IRQ_ALARM];
	endproperty
	a_alarm_irq: assert property (p_alarm_irq) else $error("alarm event lost");

	property p_clear;
		wr_en && address_i == OFF_IRQ_STAT && writedata_i[IRQ_REJECT]
			|=> !irq_status[IRQ_REJECT];
	endproperty
	a_clear: assert property (p_clear) else $error("status bit not cleared");

	property p_keep_sel;
		wr_en && !sel_hit |=> $stable(sel[0]) && $stable(sel[1]) && $stable(sel[2]);
	endproperty
	a_keep_sel: assert property (p_keep_sel)
		else $error("selection changed by another register");

	property p_read_sel;
		read_i && waitrequest_o && address_i == OFF_SEL2 |=> readdata_o == DW'(sel[1]);
	endproperty
	a_read_sel: assert property (p_read_sel)
		else $error("selection read back wrong");

	property p_analog_hidden;
		read_i && waitrequest_o && address_i == OFF_SEL3 && analog_option_i
			|=> readdata_o[SEL_W-1:0] == '0;
	endproperty
	a_analog_hidden: assert property (p_analog_hidden)
		else $error("locked selection was readable");

	// spot checks of the decode on relay one; the other slots share the function
	sequence s_sel1_full_write;
		wr_en && address_i == OFF_SEL1 && !compact_variant_i;
	endsequence

	property p_freq_codes;
		s_sel1_full_write ##0 (writedata_i inside {[32'h00000000:32'h00000008],
			[32'h0000000A:32'h00000010]}) |=> sel[0] == $past(wr_code);
	endproperty
	a_freq_codes: assert property (p_freq_codes)
		else $error("frequency, fault or current code refused");

	property p_run_codes;
		s_sel1_full_write ##0 (writedata_i inside {32'h0000002D, 32'h0000002E})
			|=> sel[0] == $past(wr_code);
	endproperty
	a_run_codes: assert property (p_run_codes)
		else $error("running or power-fail code refused");

	property p_contactor_codes;
		s_sel1_full_write ##0 (writedata_i inside {[32'h00000047:32'h0000004E]})
			|=> sel[0] == $past(wr_code);
	endproperty
	a_contactor_codes: assert property (p_contactor_codes)
		else $error("contactor code refused");

	property p_tuning_codes;
		s_sel1_full_write ##0 (writedata_i inside {32'h00000027, 32'h00000054})
			|=> sel[0] == $past(wr_code);
	endproperty
	a_tuning_codes: assert property (p_tuning_codes)
		else $error("tuning or position code refused");

endmodule
`default_nettype wire

// ---- test/host_status_model.sv ----
// host status model: status bits, option alarm and fit-out straps
`timescale 1ns/100ps
`default_nettype none
module host_status_model #(
	parameter int SIG_COUNT = 100
) (
	// host outputs
	output logic [SIG_COUNT-1:0] status_vec_o,
	output logic                 option_alarm_o,
	output logic                 compact_o,
	output logic                 analog_o
);
	// ********************************
	// stimulus, called just after a rising edge
	// ********************************
	initial begin
		status_vec_o = '0;
		option_alarm_o = 1'h0;
		compact_o = 1'h0;
		analog_o = 1'h0;
	end
	// one bit per code
	// holding a bit until told to release is how a retained signal looks
	task automatic set_sig(input int code, input logic v);
		status_vec_o[code] <= v;
	endtask
	task automatic set_alarm(input logic v);
		option_alarm_o <= v;
	endtask
	task automatic set_cfg(input logic c, input logic a);
		compact_o <= c;
		analog_o <= a;
	endtask
endmodule
`default_nettype wire

// ---- test/relay_output_selector_tb_top.sv ----
// self-checking bench for the relay output selector
`timescale 1ns/100ps
`default_nettype none
module relay_output_selector_tb_top;
	import relay_sel_pkg::*;
	logic                 clock_i = 1'h0;
	logic                 rst_i = 1'h1;
	logic [AW-1:0]        address_i = '0;
	logic                 read_i = 1'h0;
	logic                 write_i = 1'h0;
	logic [DW-1:0]        writedata_i = '0;
	logic [DW-1:0]        readdata_o;
	logic                 waitrequest_o;
	logic [SIG_COUNT-1:0] status_vec;
	logic                 alarm;
	logic                 compact;
	logic                 analog;
	logic [RELAYS-1:0]    no_closed_o;
	logic [RELAYS-1:0]    nc_closed_o;
	logic                 irq_o;
	logic [DW-1:0]        rd;
	int                   num_errors = 0;
	int                   total_checks = 0;

	always #10 clock_i = ~clock_i;

	host_status_model #(.SIG_COUNT(SIG_COUNT)) hsm_u (.status_vec_o(status_vec),
		.option_alarm_o(alarm), .compact_o(compact), .analog_o(analog));

	relay_output_selector #(.SIG_COUNT(SIG_COUNT)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .status_vec_i(status_vec),
		.option_alarm_i(alarm), .compact_variant_i(compact), .analog_option_i(analog),
		.no_closed_o(no_closed_o), .nc_closed_o(nc_closed_o), .irq_o(irq_o));

	// ********************************
	// shared tasks
	// ********************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
		address_i <= a;
		writedata_i <= d;
		write_i <= wr;
		read_i <= ~wr;
		do begin
			@(posedge clock_i);
		end while (waitrequest_o !== 1'h0);
		rd = readdata_o;
		write_i <= 1'h0;
		read_i <= 1'h0;
		@(posedge clock_i);
	endtask
	task automatic relays(input logic [DW-1:0] exp);
		repeat (2) @(posedge clock_i);
		check(32'(no_closed_o), exp);
		check(32'(nc_closed_o), ~exp & 32'h7);
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		bus(1'h0, OFF_SEL1, '0);
		check(rd, 32'h0);
		bus(1'h0, OFF_SEL2, '0);
		check(rd, 32'h1);
		bus(1'h0, OFF_SEL3, '0);
		check(rd, 32'h2);
		bus(1'h0, 5'h18, '0);
		check(rd, 32'h0);
		relays(32'h0);
		$display("test reset done");
	endtask
	task automatic t_follow();
		logic [7:0] codes [24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
			8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h27, 8'h2D, 8'h2E,
			8'h47, 8'h4A, 8'h4B, 8'h4E, 8'h54};
		foreach (codes[i]) begin
			for (int r = 0; r < RELAYS; r++) begin
				bus(1'h1, AW'(4 * r), 32'(codes[i]));
			end
			hsm_u.set_sig(int'(codes[i]), 1'h1);
			relays(32'h7);
			hsm_u.set_sig(int'(codes[i]), 1'h0);
			relays(32'h0);
		end
		bus(1'h1, OFF_SEL1, 32'h4);
		bus(1'h1, OFF_SEL2, 32'h5);
		bus(1'h1, OFF_SEL3, 32'h6);
		hsm_u.set_sig(5, 1'h1);
		relays(32'h2);
		hsm_u.set_sig(5, 1'h0);
		$display("test follow done");
	endtask
	task automatic t_reject();
		logic [DW-1:0] bad [3] = '{32'h9, 32'h64, 32'h10004};
		bus(1'h1, OFF_IRQ_STAT, 32'h7);
		foreach (bad[i]) begin
			bus(1'h1, OFF_SEL1, bad[i]);
			bus(1'h0, OFF_SEL1, '0);
			check(rd, 32'h4);
			bus(1'h0, OFF_IRQ_STAT, '0);
			check(rd & 32'h1, 32'h1);
			bus(1'h1, OFF_IRQ_STAT, 32'h1);
		end
		bus(1'h1, OFF_SEL1, 32'h9);
		check(32'(irq_o), 32'h0);
		bus(1'h1, OFF_IRQ_MASK, 32'h1);
		check(32'(irq_o), 32'h1);
		bus(1'h1, OFF_IRQ_STAT, 32'h1);
		check(32'(irq_o), 32'h0);
		$display("test reject done");
	endtask
	task automatic t_alarm();
		for (int r = 0; r < RELAYS; r++) begin
			bus(1'h1, AW'(4 * r), 32'h0);
		end
		bus(1'h1, OFF_IRQ_STAT, 32'h7);
		bus(1'h0, OFF_IRQ_STAT, '0);
		check(rd & 32'h4, 32'h0);
		hsm_u.set_sig(0, 1'h1);
		relays(32'h7);
		bus(1'h0, OFF_IRQ_STAT, '0);
		check(rd & 32'h4, 32'h4);
		hsm_u.set_alarm(1'h1);
		relays(32'h0);
		bus(1'h0, OFF_STATE, '0);
		check(rd, 32'h8);
		bus(1'h0, OFF_IRQ_STAT, '0);
		check(rd & 32'h2, 32'h2);
		hsm_u.set_alarm(1'h0);
		relays(32'h7);
		hsm_u.set_sig(0, 1'h0);
		$display("test alarm done");
	endtask
	task automatic t_option();
		bus(1'h1, OFF_SEL3, 32'h5);
		hsm_u.set_cfg(1'h0, 1'h1);
		bus(1'h1, OFF_SEL3, 32'h7);
		bus(1'h0, OFF_SEL3, '0);
		check(rd, 32'h0);
		bus(1'h0, OFF_STATE, '0);
		check(rd & 32'h30, 32'h20);
		hsm_u.set_cfg(1'h0, 1'h0);
		bus(1'h0, OFF_SEL3, '0);
		check(rd, 32'h5);
		// compact strap is sampled by reset, so reset again with it set
		hsm_u.set_cfg(1'h1, 1'h0);
		rst_i <= 1'h1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'h0;
		@(posedge clock_i);
		bus(1'h0, OFF_SEL3, '0);
		check(rd, 32'h4);
		bus(1'h0, OFF_STATE, '0);
		check(rd & 32'h30, 32'h10);
		bus(1'h1, OFF_SEL1, 32'h2);
		bus(1'h0, OFF_SEL1, '0);
		check(rd, 32'h0);
		bus(1'h1, OFF_SEL1, 32'h3);
		bus(1'h0, OFF_SEL1, '0);
		check(rd, 32'h3);
		$display("test option done");
	endtask

	initial begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'h0;
		@(posedge clock_i);
		t_reset();
		t_follow();
		t_reject();
		t_alarm();
		t_option();
		end_sim();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
